// [lt_model.sv]
// Line termination model facing the network termination
`timescale 1ns/100ps
module lt_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic exch_req,
   input wire logic in_sync,
   output logic lt_act_req,
   output logic [1:0] line_sig
);
   logic [2:0] lt_r;
   // Exchange request acts in ready only; sync ends training
   always_ff @(posedge clock) begin
      if (reset) lt_r <= 3'h1;
      else if (exch_req && lt_r == 3'h1) lt_r <= 3'h2;
      else if (in_sync && lt_r == 3'h2) lt_r <= 3'h3;
   end
   assign line_sig = {lt_r == 3'h3, lt_r == 3'h2};
   assign lt_act_req = exch_req && lt_r == 3'h1;
endmodule

// [nt_act_chk_properties.sv]
// Port checker for the activation state machine
`timescale 1ns/100ps
module nt_act_chk
   import nt_act_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic no_line_signal,
   input nt_state_t state_r,
   input te_sig_t te_sig_r,
   input wire logic synced_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Signal toward the terminal and sync flag follow the state
   AST_I0: assert property (state_r inside {3'h1, 3'h2, 3'h6}
      |-> te_sig_r == 2'h0) else $error("te sig not I0");
   AST_I2: assert property (state_r inside {3'h3, 3'h4}
      |-> te_sig_r == 2'h1) else $error("te sig not I2");
   AST_I4: assert property (state_r == 3'h5 |-> te_sig_r == 2'h2)
      else $error("te sig not I4");
   AST_MUTE: assert property (state_r == 3'h7 |-> te_sig_r == 2'h3)
      else $error("te sig not silent");
   AST_SYNC: assert property (synced_r == state_r inside {3'h3, 3'h4, 3'h5})
      else $error("sync flag wrong");
   // Legal entries into states
   AST_STEP: assert property ($changed(state_r) && state_r > 3'h2
      && state_r < 3'h6 |-> $past(state_r) == state_r - 3'h1)
      else $error("skipped step");
   AST_IN2: assert property ($changed(state_r) && state_r == 3'h2
      |-> $past(state_r) inside {3'h1, 3'h6}) else $error("bad entry 2");
   AST_IN7: assert property ($changed(state_r) && state_r == 3'h7
      |-> $past(state_r) inside {[3'h2:3'h5]}) else $error("bad entry 7");
   AST_IN6: assert property ($changed(state_r) && state_r == 3'h6
      |-> $past(state_r) == 3'h1) else $error("bad entry 6");
   AST_IN1: assert property ($changed(state_r) && state_r == 3'h1
      |-> $past(state_r) == 3'h7) else $error("bad entry 1");
   AST_NOLINE: assert property (state_r == 3'h7 && no_line_signal
      |-> ##[1:5] state_r == 3'h1) else $error("stuck in 7");
endmodule

bind nt_activation nt_act_chk chk_u (.clock, .reset, .no_line_signal,
   .state_r, .te_sig_r, .synced_r);

// [nt_act_defs.sv]
// Package of state and signal codes, plus the hold-off timer module
package nt_act_pkg;
   // Activation states of the network termination
   typedef enum logic [2:0] {
      NT_READY    = 3'h1,
      NT_TRAINING = 3'h2,
      NT_WAIT_T   = 3'h3,
      NT_WAIT_DV  = 3'h4,
      NT_STEADY   = 3'h5,
      NT_TE_ACT   = 3'h6,
      NT_PEND_DEA = 3'h7
   } nt_state_t;

   // Signal sent toward the terminal
   typedef enum logic [1:0] {
      TE_SIG_I0   = 2'h0,
      TE_SIG_I2   = 2'h1,
      TE_SIG_I4   = 2'h2,
      TE_SIG_NONE = 2'h3
   } te_sig_t;

   // Event input bit positions
   localparam int EV_LT_ACT = 0;
   localparam int EV_SYNC_OK = 1;
   localparam int EV_INFO3 = 2;
   localparam int EV_DATA_VALID = 3;
   localparam int EV_TE_ACT = 4;
   localparam int EV_SYNC_LOST = 5;
   localparam int EV_NO_LINE = 6;
   localparam int EV_COUNT = 7;

   // Timing
   localparam int CLOCK_HZ = 10000000;
   localparam int DEACT_TIMEOUT_US = 65000;
   // Longest time rounds down to whole cycles
   localparam int DEACT_TIMEOUT_CYC =
      int'((64'(DEACT_TIMEOUT_US) * 64'(CLOCK_HZ)) / 64'd1000000);
   localparam int TIMER_W = 20;

   // Reset values
   localparam nt_state_t STATE_RST = NT_READY;
   localparam te_sig_t TE_SIG_RST = TE_SIG_I0;
endpackage

`timescale 1ns/100ps
// Counts while run is high; done_r rises after limit cycles
module nt_hold_timer
   import nt_act_pkg::*;
#(
   parameter logic [TIMER_W-1:0] LIMIT = TIMER_W'(DEACT_TIMEOUT_CYC)
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic run,
   output logic done_r
);
   logic [TIMER_W-1:0] count_r;
   logic [TIMER_W-1:0] count_nxt;
   logic done_nxt;

   // Counter clears whenever run drops
   always_comb begin
      count_nxt = count_r;
      done_nxt = done_r;
      if (!run) begin
         count_nxt = '0;
         done_nxt = 1'b0;
      end else if (count_r < LIMIT - TIMER_W'(1)) begin
         count_nxt = count_r + TIMER_W'(1);
      end else begin
         done_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         count_r <= '0;
         done_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         done_r <= done_nxt;
      end
   end
endmodule

// [nt_activation.sv]
// Network termination activation and deactivation state machine
`timescale 1ns/100ps
module nt_activation
   import nt_act_pkg::*;
#(
   parameter int DEACT_CYCLES = DEACT_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic lt_act_req,
   input wire logic sync_ok,
   input wire logic info3_rx,
   input wire logic data_valid,
   input wire logic te_act_req,
   input wire logic sync_lost,
   input wire logic no_line_signal,
   output nt_state_t state_r,
   output te_sig_t te_sig_r,
   output logic synced_r,
   output logic terminate_r
);
   // Event pins as one vector, then two flop stages per pin
   // Every pin is level sensitive: a held pin acts on each cycle
   logic [EV_COUNT-1:0] ev_raw;
   logic [EV_COUNT-1:0] meta_r;
   logic [EV_COUNT-1:0] ev_r;
   nt_state_t state_nxt;
   te_sig_t te_sig_nxt;
   logic synced_nxt;
   logic terminate_nxt;
   logic timer_run;
   logic timer_done;

   // Gather pin events into one vector
   assign ev_raw[EV_LT_ACT] = lt_act_req;
   assign ev_raw[EV_SYNC_OK] = sync_ok;
   assign ev_raw[EV_INFO3] = info3_rx;
   assign ev_raw[EV_DATA_VALID] = data_valid;
   assign ev_raw[EV_TE_ACT] = te_act_req;
   assign ev_raw[EV_SYNC_LOST] = sync_lost;
   assign ev_raw[EV_NO_LINE] = no_line_signal;

   // Two-flop synchronisers, one per event pin
   // Only the second stage feeds the state table, so a pin that
   // changes near a clock edge cannot split the state decode
   // Each event reaches the table one edge after the pin is sampled
   genvar gi;
   generate
      for (gi = 0; gi < EV_COUNT; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (reset) begin
               meta_r[gi] <= 1'b0;
               ev_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= ev_raw[gi];
               ev_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   // Hold-off timer runs while pending deactivation
   // It restarts from zero on every entry into pending deactivation
   // Failed activation is not timed here; only loss of sync starts it
   assign timer_run = (state_r == NT_PEND_DEA);

   nt_hold_timer #(
      .LIMIT(TIMER_W'(DEACT_CYCLES))
   ) u_timer (
      .clock(clock),
      .reset(reset),
      .run(timer_run),
      .done_r(timer_done)
   );

   // Each state acts on a few events only; any other event is either
   // no-change or impossible and falls through to hold the state.
   // Loss of sync outranks the advancing event in states 2..4, so a
   // sync drop during training never lands in a later state.
   // In ready, a line request outranks a terminal request when both
   // arrive together; training is the common next step either way.
   // Pending deactivation leaves only on loss of line signal; the
   // hold-off timer only flags that operation should end.
   // Next-state table; unlisted events keep the state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         // Ready: line or terminal request starts activation
         NT_READY: begin
            if (ev_r[EV_LT_ACT]) begin
               state_nxt = NT_TRAINING;
            end else if (ev_r[EV_TE_ACT]) begin
               state_nxt = NT_TE_ACT;
            end
         end
         // Training: sync achieved or lost
         NT_TRAINING: begin
            if (ev_r[EV_SYNC_LOST]) begin
               state_nxt = NT_PEND_DEA;
            end else if (ev_r[EV_SYNC_OK]) begin
               state_nxt = NT_WAIT_T;
            end
         end
         // Waiting for the terminal's answer
         NT_WAIT_T: begin
            if (ev_r[EV_SYNC_LOST]) begin
               state_nxt = NT_PEND_DEA;
            end else if (ev_r[EV_INFO3]) begin
               state_nxt = NT_WAIT_DV;
            end
         end
         // Waiting for data valid
         NT_WAIT_DV: begin
            if (ev_r[EV_SYNC_LOST]) begin
               state_nxt = NT_PEND_DEA;
            end else if (ev_r[EV_DATA_VALID]) begin
               state_nxt = NT_STEADY;
            end
         end
         // Steady state: only loss of sync acts
         NT_STEADY: begin
            if (ev_r[EV_SYNC_LOST]) begin
               state_nxt = NT_PEND_DEA;
            end
         end
         // Terminal-initiated: wait for the line request
         NT_TE_ACT: begin
            if (ev_r[EV_LT_ACT]) begin
               state_nxt = NT_TRAINING;
            end
         end
         // Pending deactivation: wait for the line to go quiet
         NT_PEND_DEA: begin
            // Terminal request ignored here
            if (ev_r[EV_NO_LINE]) begin
               state_nxt = NT_READY;
            end
         end
         default: begin
            state_nxt = STATE_RST;
         end
      endcase
   end

   // Signal toward terminal follows the next state
   always_comb begin
      unique case (state_nxt)
         NT_READY: te_sig_nxt = TE_SIG_I0;
         NT_TRAINING: te_sig_nxt = TE_SIG_I0;
         NT_WAIT_T: te_sig_nxt = TE_SIG_I2;
         NT_WAIT_DV: te_sig_nxt = TE_SIG_I2;
         NT_STEADY: te_sig_nxt = TE_SIG_I4;
         NT_TE_ACT: te_sig_nxt = TE_SIG_I0;
         NT_PEND_DEA: te_sig_nxt = TE_SIG_NONE;
         default: te_sig_nxt = TE_SIG_I0; // Illegal code
      endcase
   end

   // Synchronized flag for states 3..5
   always_comb begin
      unique case (state_nxt)
         NT_WAIT_T: synced_nxt = 1'b1;
         NT_WAIT_DV: synced_nxt = 1'b1;
         NT_STEADY: synced_nxt = 1'b1;
         default: synced_nxt = 1'b0;
      endcase
   end

   // Operation ends once the hold-off expires in state 7
   // The flag drops in the same cycle the state leaves state 7
   always_comb begin
      terminate_nxt = timer_done && (state_nxt == NT_PEND_DEA);
   end

   // State and output registers
   // All outputs update on one edge, so they never disagree
   // Reset value is ready for activation, sending I0
   always_ff @(posedge clock) begin
      if (reset) begin
         state_r <= STATE_RST;
         te_sig_r <= TE_SIG_RST;
         synced_r <= 1'b0;
         terminate_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         te_sig_r <= te_sig_nxt;
         synced_r <= synced_nxt;
         terminate_r <= terminate_nxt;
      end
   end
endmodule

// [nt_activation_test.sv]
// Self-checking bench for the activation state machine
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin \
   $display("ERROR %s exp %0h got %0h", n, e, s); bad_count++; end end
module nt_activation_test
   import nt_act_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [EV_COUNT-1:0] ev_r = '0;
   logic lt_req, synced_r, terminate_r;
   nt_state_t state_r, want, exp_q[$];
   nt_state_t seen = NT_READY;
   te_sig_t te_sig_r;
   int bad_count = 0;
   int num_checks = 0;
   always #50 clock = ~clock;
   // Far end; line returns to ready once quiet
   lt_model lt_u (.clock, .reset(reset || ev_r[EV_NO_LINE]),
      .exch_req(ev_r[EV_LT_ACT]), .in_sync(ev_r[EV_SYNC_OK]),
      .lt_act_req(lt_req), .line_sig());
   nt_activation #(.DEACT_CYCLES(20)) dut_u (.clock, .reset,
      .lt_act_req(lt_req), .sync_ok(ev_r[EV_SYNC_OK]),
      .info3_rx(ev_r[EV_INFO3]), .data_valid(ev_r[EV_DATA_VALID]),
      .te_act_req(ev_r[EV_TE_ACT]), .sync_lost(ev_r[EV_SYNC_LOST]),
      .no_line_signal(ev_r[EV_NO_LINE]), .state_r, .te_sig_r,
      .synced_r, .terminate_r);
   function automatic te_sig_t sig_of(nt_state_t s);
      case (s)
         NT_WAIT_T, NT_WAIT_DV: return TE_SIG_I2;
         NT_STEADY: return TE_SIG_I4;
         NT_PEND_DEA: return TE_SIG_NONE;
         default: return TE_SIG_I0;
      endcase
   endfunction
   // Each state change takes the oldest expected state
   always @(negedge clock) begin
      if (!reset && state_r !== seen) begin
         want = exp_q.size() ? exp_q.pop_front() : seen;
         `CHK("state", want, state_r)
         `CHK("te_sig", sig_of(want), te_sig_r)
         `CHK("synced", want inside {NT_WAIT_T, NT_WAIT_DV, NT_STEADY}, synced_r)
         `CHK("term_chg", 1'b0, terminate_r)
         seen = state_r;
      end
   end
   task automatic final_report;
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One-cycle event; nx of 0 means no change is expected
   task automatic ev(input int b, input int nx);
      int n;
      @(posedge clock);
      ev_r[b] <= 1'b1;
      @(posedge clock);
      ev_r[b] <= 1'b0;
      if (nx != 0) exp_q.push_back(nt_state_t'(nx));
      for (n = 0; exp_q.size() && n < 12; n++) @(posedge clock);
      if (n >= 12) begin
         bad_count++;
         final_report;
      end
      repeat ($urandom_range(6, 9)) @(posedge clock);
   endtask
   // Main sequence
   initial begin
      void'($urandom(63832));
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      ev(EV_TE_ACT, NT_TE_ACT);
      ev(EV_LT_ACT, NT_TRAINING);
      ev(EV_SYNC_OK, NT_WAIT_T);
      ev(EV_INFO3, NT_WAIT_DV);
      ev(EV_DATA_VALID, NT_STEADY);
      ev(EV_NO_LINE, 0);
      ev(EV_SYNC_LOST, NT_PEND_DEA);
      @(negedge clock);
      `CHK("term", 1'b0, terminate_r)
      repeat (6) ev($urandom_range(0, 5), 0);
      @(negedge clock);
      `CHK("term", 1'b1, terminate_r)
      ev(EV_NO_LINE, NT_READY);
      ev(EV_LT_ACT, NT_TRAINING);
      ev(EV_SYNC_LOST, NT_PEND_DEA);
      ev(EV_NO_LINE, NT_READY);
      final_report;
   end
endmodule
